// ---- design/edge_prescaler.v ----
/*
 * Programmable power-of-two prescaler: counts qualifying events and
 * toggles its output once per full division period, so every change of
 * the output level stands for one completed period.
 * Assumes events are one-cycle pulses synchronous to clk.
 */
`include "timer0_consts.vh"

module edge_prescaler #(
    parameter WIDTH = 8
) (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Control
    input wire clear,
    input wire [3:0] ratio_code,
    input wire event_in,
    // Result
    output reg out_r,
    output reg bypass_r
);

    reg [WIDTH-1:0] count_r;
    reg [WIDTH-1:0] period_mask;

    // Division period minus one, as a mask
    always @*
    begin
        if (ratio_code >= `PS_MAX_CODE)
            period_mask = {WIDTH{1'b1}};
        else if (ratio_code == 4'h0)
            period_mask = {WIDTH{1'b0}};
        else
            period_mask = (({{(WIDTH-1){1'b0}}, 1'b1} << ratio_code) - 1'b1);
    end

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count_r <= {WIDTH{1'b0}};
            out_r <= 1'b0;
            bypass_r <= 1'b1;
        end
        else
        begin
            bypass_r <= (ratio_code == 4'h0);
            // Level kept on clear: dropping it would fake one count step
            if (clear)
                count_r <= {WIDTH{1'b0}};
            else if (event_in)
            begin
                if ((count_r & period_mask) == period_mask)
                begin
                    count_r <= {WIDTH{1'b0}};
                    out_r <= ~out_r;
                end
                else
                    count_r <= count_r + 1'b1;
            end
        end
    end

endmodule

// ---- design/timer0_consts.vh ----
/*
 * Constants for the prescaled 16-bit timer: register map, field positions,
 * reset values and timing figures.
 * Assumes inclusion by bare name from the design files and the bench.
 */
`ifndef TIMER0_CONSTS_VH
`define TIMER0_CONSTS_VH

// ------------------------------------------------------------
// Register byte addresses
// ------------------------------------------------------------
// Full five-bit width so the upper offsets do not fold onto the lower ones
`define ADDR_STATUS_CONTROL 5'h00
`define ADDR_COUNTER_LOW 5'h04
`define ADDR_COUNTER_HIGH 5'h08
`define ADDR_IRQ_STATUS 5'h0c
`define ADDR_IRQ_ENABLE 5'h10
`define ADDR_IRQ_CLEAR 5'h14
`define ADDR_IRQ_ACK 5'h18

// ------------------------------------------------------------
// Control field positions and reset values
// ------------------------------------------------------------
`define CTL_EDGE_BIT 6
`define CTL_SRC_BIT 5
`define CTL_PS_HI 4
`define CTL_PS_LO 1
`define CTL_RESET 8'h00
`define CTL_WMASK 8'h7e

// ------------------------------------------------------------
// Timing, prescaler limit and AXI response codes
// ------------------------------------------------------------
`define OSC_PER_INSTR 4
`define PS_MAX_CODE 4'h8
`define AXI_OKAY 2'b00
`define AXI_SLVERR 2'b10

`endif

// ---- design/timer0_prescaled_counter.v ----
/*
 * Top of the prescaled 16-bit timer/counter with AXI4-Lite register slave.
 * Assumes a 40 MHz clk taken as the oscillator, the instruction cycle being
 * four clk periods, and an external count pin synchronous to clk.
 */
// Design decisions made here: the address map and register access over AXI4-Lite.
// Summary of operation
// - Source bit one selects instruction clock
// - Edge bit selects rising or falling pin
// - Four-bit code divides by powers of two
// - Sixteen-bit counter wraps from maximum to zero
// - Each wrap sets the overflow flag
// - Enable bit gates request, flag still sets
// - Interrupt vectoring clears flag automatically
// - Pin goes through prescaler, then synchroniser
// - Prescaler output sampled twice per instruction
// - Edge to increment takes four to five
// - Counter byte write clears prescaler
// - Written byte holds for following cycle
`include "timer0_consts.vh"

module timer0_prescaled_counter #(
    parameter PS_WIDTH = 8
) (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Count pin and interrupt vectoring
    input wire external_count_pin,
    input wire irq_vector_ack,
    output reg irq_r,
    // AXI4-Lite write address
    input wire [4:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    // AXI4-Lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // AXI4-Lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read address
    input wire [4:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    // AXI4-Lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    reg [7:0] timer0_status_control_r;
    reg [7:0] counter_low_byte_r;
    reg [7:0] counter_high_byte_r;
    reg overflow_irq_flag_r;
    reg overflow_irq_enable_r;
    reg [1:0] phase_r;
    reg pin_d_r;
    reg hold_low_r;
    reg hold_high_r;
    reg samp1_r;
    reg samp2_r;
    reg [4:0] aw_addr_r;
    reg aw_have_r;
    reg [31:0] w_data_r;
    reg [3:0] w_strb_r;
    reg w_have_r;

    wire count_source_select = timer0_status_control_r[`CTL_SRC_BIT];
    wire count_edge_select = timer0_status_control_r[`CTL_EDGE_BIT];
    wire [3:0] prescale_ratio_field = timer0_status_control_r[`CTL_PS_HI:`CTL_PS_LO];

    // ------------------------------------------------------------
    // Instruction-cycle phase divider
    // ------------------------------------------------------------
    wire instr_tick = (phase_r == 2'd3);
    wire half_tick = phase_r[0];

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            phase_r <= 2'd0;
        else
            phase_r <= phase_r + 2'd1;
    end

    // ------------------------------------------------------------
    // Count event selection and prescaler
    // ------------------------------------------------------------
    wire pin_rise = external_count_pin & ~pin_d_r;
    wire pin_fall = ~external_count_pin & pin_d_r;
    wire pin_edge = count_edge_select ? pin_rise : pin_fall;
    wire raw_event = count_source_select ? instr_tick : pin_edge;

    wire write_fire;
    wire wr_low;
    wire wr_high;
    wire prescaler_output;
    wire ps_bypass;

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            pin_d_r <= 1'b0;
        else
            pin_d_r <= external_count_pin;
    end

    // Raw pin edges feed the prescaler directly, ahead of any sync
    edge_prescaler #(
        .WIDTH(PS_WIDTH)
    ) u_prescaler (
        .clk(clk),
        .rst_n(rst_n),
        .clear(wr_low | wr_high),
        .ratio_code(prescale_ratio_field),
        .event_in(raw_event),
        .out_r(prescaler_output),
        .bypass_r(ps_bypass)
    );

    // ------------------------------------------------------------
    // Synchroniser: two samples per instruction cycle
    // ------------------------------------------------------------
    // With 1:1 in external mode the pin edge itself toggles this level,
    // so the same edge detector serves both cases.
    reg bypass_lvl_r;
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            bypass_lvl_r <= 1'b0;
        else if (raw_event)
            bypass_lvl_r <= ~bypass_lvl_r;
    end

    wire ps_level = ps_bypass ? bypass_lvl_r : prescaler_output;

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            samp1_r <= 1'b0;
            samp2_r <= 1'b0;
        end
        else if (half_tick)
        begin
            samp1_r <= ps_level;
            samp2_r <= samp1_r;
        end
    end

    // Any change of the divided level is one full division period done;
    // latency from pin edge is 4 to 5 clk periods with this sampling.
    wire count_step = half_tick & (samp1_r != samp2_r);

    // ------------------------------------------------------------
    // AXI4-Lite write path
    // ------------------------------------------------------------
    assign write_fire = aw_have_r & w_have_r & ~s_axi_bvalid;
    assign wr_low = write_fire & (aw_addr_r == `ADDR_COUNTER_LOW) & w_strb_r[0];
    assign wr_high = write_fire & (aw_addr_r == `ADDR_COUNTER_HIGH) & w_strb_r[0];
    wire wr_ctl = write_fire & (aw_addr_r == `ADDR_STATUS_CONTROL) & w_strb_r[0];
    wire wr_en = write_fire & (aw_addr_r == `ADDR_IRQ_ENABLE) & w_strb_r[0];
    wire wr_clr = write_fire & (aw_addr_r == `ADDR_IRQ_CLEAR) & w_strb_r[0] & w_data_r[0];
    wire w_mapped = (aw_addr_r == `ADDR_STATUS_CONTROL) || (aw_addr_r == `ADDR_COUNTER_LOW) ||
                    (aw_addr_r == `ADDR_COUNTER_HIGH) || (aw_addr_r == `ADDR_IRQ_ENABLE) ||
                    (aw_addr_r == `ADDR_IRQ_CLEAR) || (aw_addr_r == `ADDR_IRQ_ACK);
    wire wr_ack = write_fire & (aw_addr_r == `ADDR_IRQ_ACK) & w_strb_r[0] & w_data_r[0];

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aw_have_r <= 1'b0;
            aw_addr_r <= 5'h00;
            w_have_r <= 1'b0;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `AXI_OKAY;
        end
        else
        begin
            s_axi_awready <= ~aw_have_r & ~s_axi_awready & s_axi_awvalid;
            s_axi_wready <= ~w_have_r & ~s_axi_wready & s_axi_wvalid;
            if (s_axi_awvalid & s_axi_awready)
            begin
                aw_have_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready)
            begin
                w_have_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (write_fire)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= w_mapped ? `AXI_OKAY : `AXI_SLVERR;
            end
            else if (s_axi_bvalid & s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Control register and counter
    // ------------------------------------------------------------
    // A held or overwritten low byte passes no carry upward
    wire low_inc = count_step & ~hold_low_r & ~wr_low;
    wire [8:0] low_sum = {1'b0, counter_low_byte_r} + 9'h001;
    wire high_inc = low_inc & ~hold_high_r & ~wr_high & low_sum[8];
    wire wrap = high_inc & (counter_high_byte_r == 8'hff);

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            timer0_status_control_r <= `CTL_RESET;
            counter_low_byte_r <= 8'h00;
            counter_high_byte_r <= 8'h00;
            hold_low_r <= 1'b0;
            hold_high_r <= 1'b0;
        end
        else
        begin
            hold_low_r <= wr_low;
            hold_high_r <= wr_high;
            if (wr_ctl)
                timer0_status_control_r <= w_data_r[7:0] & `CTL_WMASK;
            if (wr_low)
                counter_low_byte_r <= w_data_r[7:0];
            else if (low_inc)
                counter_low_byte_r <= low_sum[7:0];
            if (wr_high)
                counter_high_byte_r <= w_data_r[7:0];
            else if (high_inc)
                counter_high_byte_r <= counter_high_byte_r + 8'h01;
        end
    end

    // ------------------------------------------------------------
    // Overflow flag and interrupt
    // ------------------------------------------------------------
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            overflow_irq_flag_r <= 1'b0;
            overflow_irq_enable_r <= 1'b0;
            irq_r <= 1'b0;
        end
        else
        begin
            if (wr_en)
                overflow_irq_enable_r <= w_data_r[0];
            // Set wins over a simultaneous clear so no wrap is lost
            if (wrap)
                overflow_irq_flag_r <= 1'b1;
            else if (irq_vector_ack | wr_ack | wr_clr)
                overflow_irq_flag_r <= 1'b0;
            irq_r <= (overflow_irq_flag_r | wrap) & overflow_irq_enable_r &
                     ~((irq_vector_ack | wr_ack) & ~wrap);
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read path
    // ------------------------------------------------------------
    reg [31:0] rd_word;
    reg rd_ok;
    always @*
    begin
        rd_word = 32'h0000_0000;
        rd_ok = 1'b1;
        case (s_axi_araddr)
            `ADDR_STATUS_CONTROL: rd_word = {24'h000000, timer0_status_control_r};
            `ADDR_COUNTER_LOW: rd_word = {24'h000000, counter_low_byte_r};
            `ADDR_COUNTER_HIGH: rd_word = {24'h000000, counter_high_byte_r};
            `ADDR_IRQ_STATUS: rd_word = {31'h00000000, overflow_irq_flag_r};
            `ADDR_IRQ_ENABLE: rd_word = {31'h00000000, overflow_irq_enable_r};
            `ADDR_IRQ_CLEAR: rd_word = 32'h0000_0000;
            `ADDR_IRQ_ACK: rd_word = 32'h0000_0000;
            default: rd_ok = 1'b0;
        endcase
    end

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `AXI_OKAY;
        end
        else
        begin
            s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
            if (s_axi_arvalid & s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_ok ? `AXI_OKAY : `AXI_SLVERR;
            end
            else if (s_axi_rvalid & s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

endmodule

// ---- tb/ext_clock_src.sv ----
/*
 * Model of the external clock source on the count pin.
 * Assumes go is a one-cycle pulse driven on the clk rising edge.
 */
module ext_clock_src (
    // Clock and control
    input wire logic clk,
    input wire logic go,
    input wire logic [15:0] n,
    input wire logic [2:0] half,
    // Pin side
    output logic pin,
    output logic busy
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] left_r;
    logic [2:0] cnt_r;
    initial
    begin
        pin = 1'b0;
        busy = 1'b0;
    end
    // Level holds between bursts so the bench knows every edge it made
    always @(posedge clk)
        if (go)
        begin
            left_r <= n;
            cnt_r <= half;
            busy <= (n != 16'h0);
        end
        else if (busy && cnt_r <= 3'h1)
        begin
            pin <= ~pin;
            cnt_r <= half;
            left_r <= left_r - 16'h1;
            busy <= (left_r != 16'h1);
        end
        else if (busy)
            cnt_r <= cnt_r - 3'h1;
endmodule

// ---- tb/tb.sv ----
/*
 * Self-checking bench for the prescaled timer over AXI4-Lite.
 * Assumes the partner model drives the count pin.
 */
`include "timer0_consts.vh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n, external_count_pin, irq_vector_ack, irq_r, go, busy;
    logic [4:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, lf, d;
    logic [3:0] s_axi_wstrb;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [15:0] n;
    logic [2:0] half;
    logic [7:0] base;
    int n_fail, samples_checked, i, t, code, es, k, nt, q;
    timer0_prescaled_counter timer0_prescaled_counter_i (.clk, .rst_n, .external_count_pin,
        .irq_vector_ack, .irq_r, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);
    ext_clock_src ext_clock_src_i (.clk, .go, .n, .half, .pin(external_count_pin), .busy);
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [7:0] exp_inc(input int c, input int e);
        return 8'(c >= 8 ? e / 256 : e >> c);
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e)
        begin
            n_fail++;
            $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
        chk({30'h0, g}, {30'h0, e});
    endtask
    // Waits for the answer however long it takes; only the watchdog ends a hang
    task automatic wr(input logic [4:0] a, input logic [7:0] v, output logic [1:0] rs);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, v};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [4:0] a, output logic [31:0] v, output logic [1:0] rs);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        v = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr_ok(input logic [4:0] a, input logic [7:0] v);
        logic [1:0] rs;
        wr(a, v, rs);
        chk_resp(rs, `AXI_OKAY);
    endtask
    task automatic rd_chk(input logic [4:0] a, input logic [31:0] e);
        logic [31:0] v;
        logic [1:0] rs;
        rd(a, v, rs);
        chk(v, e);
        chk_resp(rs, `AXI_OKAY);
    endtask
    task automatic start_wrap(input logic [7:0] en);
        wr_ok(5'h10, en);
        wr_ok(5'h00, 8'h20);
        wr_ok(5'h08, 8'hff);
        wr_ok(5'h04, 8'hf0);
    endtask
    task automatic conclude;
        $display("checked %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        repeat (90000) @(posedge clk);
        n_fail++;
        conclude();
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        {rst_n, irq_vector_ack, go, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 6'h0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
        n = 16'h0;
        half = 3'h4;
        s_axi_wstrb = 4'h1;
        lf = 32'h864b;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (i = 0; i < 5; i++) rd_chk(5'(i * 4), 32'h0);
        wr_ok(5'h00, 8'hff);
        rd_chk(5'h00, 32'h7e);
        wr(5'h1c, 8'h01, r);
        chk_resp(r, `AXI_SLVERR);
        rd(5'h1c, d, r);
        chk_resp(r, `AXI_SLVERR);
        start_wrap(8'h01);
        for (t = 0; t < 400 && irq_r !== 1'b1; t++) @(posedge clk);
        chk({31'h0, irq_r}, 32'h1);
        rd_chk(5'h08, 32'h0);
        wr_ok(5'h00, 8'h00);
        rd_chk(5'h0c, 32'h1);
        irq_vector_ack <= 1'b1;
        @(posedge clk);
        irq_vector_ack <= 1'b0;
        repeat (3) @(posedge clk);
        rd_chk(5'h0c, 32'h0);
        start_wrap(8'h00);
        repeat (150) @(posedge clk);
        chk({31'h0, irq_r}, 32'h0);
        wr_ok(5'h00, 8'h00);
        rd_chk(5'h0c, 32'h1);
        wr_ok(5'h14, 8'h01);
        rd_chk(5'h0c, 32'h0);
        for (i = 0; i < 12; i++)
        begin
            lf = lfsr(lf);
            code = i < 10 ? i : 0;
            es = i == 10 ? 0 : (i == 11 ? 1 : int'(lf[0]));
            k = code > 4 ? 1 : 1 + int'(lf[2:1]);
            // One edge past a whole period only at 1:1, where it shows the edge choice
            nt = code == 0 ? 2 * k + 1 : 2 * k * (code >= 8 ? 256 : 1 << code);
            q = es ? (external_count_pin ? nt / 2 : (nt + 1) / 2) : 0;
            q = es ? q : (external_count_pin ? (nt + 1) / 2 : nt / 2);
            wr_ok(5'h00, {1'b0, es[0], 1'b0, code[3:0], 1'b0});
            wr_ok(5'h04, 8'h00);
            repeat (8) @(posedge clk);
            rd(5'h04, d, r);
            base = d[7:0];
            n <= 16'(nt);
            half <= 3'h4 + {1'b0, lf[4:3]};
            go <= 1'b1;
            @(posedge clk);
            go <= 1'b0;
            @(posedge clk);
            for (t = 0; t < 20000 && busy; t++) @(posedge clk);
            repeat (12) @(posedge clk);
            rd(5'h04, d, r);
            chk({24'h0, d[7:0] - base}, {24'h0, exp_inc(code, q)});
        end
        // Two pin toggles give exactly one falling edge from either level
        wr_ok(5'h00, 8'h00);
        wr_ok(5'h08, 8'h12);
        wr_ok(5'h04, 8'hff);
        n <= 16'h2;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
        for (t = 0; t < 200 && busy; t++) @(posedge clk);
        repeat (12) @(posedge clk);
        rd_chk(5'h08, 32'h13);
        rd_chk(5'h04, 32'h0);
        conclude();
    end
endmodule

// ---- tb/timer0_assertions.sv ----
/*
 * Port checker for the prescaled timer.
 * Assumes the top module ports only; attached by the bind below.
 */
module timer0_assertions (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Interrupt
    input wire irq_vector_ack,
    input wire irq_r,
    // AXI4-Lite
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_rready
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence aw_t;
        s_axi_awvalid && s_axi_awready;
    endsequence
    sequence w_t;
        s_axi_wvalid && s_axi_wready;
    endsequence
    AST_AW_PULSE:
        assert property (s_axi_awready |=> !s_axi_awready) else $error("awready too long");
    AST_B_AFTER:
        assert property (aw_t ##0 w_t |-> ##[1:3] s_axi_bvalid) else $error("no bvalid");
    AST_B_DROP:
        assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid held");
    AST_AR_TO_R:
        assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no rvalid");
    AST_R_DROP:
        assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("rvalid held");
    AST_RESP_LEGAL:
        assert property (s_axi_bvalid |-> s_axi_bresp == 2'b00 || s_axi_bresp == 2'b10)
            else $error("bad bresp");
    AST_ACK_CLEARS:
        assert property (irq_vector_ack |-> ##[1:3] !irq_r) else $error("irq kept after ack");
    AST_IRQ_STICKY:
        assert property ($fell(irq_r) |-> $past(irq_vector_ack) || $past(irq_vector_ack, 2)
            || $past(irq_vector_ack, 3) || $past(s_axi_wvalid, 2) || $past(s_axi_wvalid, 3)
            || $past(s_axi_wvalid, 4)) else $error("irq fell by itself");
endmodule

bind timer0_prescaled_counter timer0_assertions timer0_assertions_i (.clk, .rst_n,
    .irq_vector_ack, .irq_r, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .s_axi_rready);
